// file: inc/sdf_pkg.sv
package sdf_pkg;

   // Modulator clocks per decimation step, per unit of filter word.
   localparam logic [19:0] DEC_PER_FW = 20'h00400;
   localparam logic [6:0]  DEC_LOG2   = 7'h0a;
   localparam logic [6:0]  RES_TOP    = 7'h17;
   localparam logic [2:0]  ORD_FOURTH = 3'h4;
   localparam logic [2:0]  ORD_THIRD  = 3'h3;
   localparam logic [9:0]  FW_ZERO    = 10'h000;
   localparam logic [9:0]  FW_RST     = 10'h060;
   localparam logic [23:0] RES_MAX    = 24'h7fffff;
   localparam int          RES_W      = 24;
   localparam int          CHAN_W     = 4;

   // Register byte offsets.
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CHAN = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;

   // Mode register fields.
   localparam int MB_FW    = 0;
   localparam int MB_ZL    = 11;
   localparam int MB_NOTCH = 13;
   localparam int MB_THIRD = 15;
   localparam int MB_CHOP  = 20;
   localparam int MB_RUN   = 24;

   // Status and data register fields.
   localparam int SB_AVAIL = 0;
   localparam int SB_FULL  = 1;
   localparam int SB_SWAP  = 2;
   localparam int SB_PEND  = 3;
   localparam int SB_DECS  = 4;
   localparam int DB_CHAN  = 24;
   localparam int DB_VALID = 31;

   typedef struct packed {
      logic       run;
      logic       chop;
      logic       notch;
      logic       third;
      logic       zero_lat;
      logic [9:0] fw;
   } sdf_cfg_t;

   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [RES_W-1:0]  data;
   } sdf_res_t;

   localparam sdf_cfg_t CFG_RST = '{run: 1'b0, chop: 1'b0, notch: 1'b0, third: 1'b0,
                                    zero_lat: 1'b0, fw: FW_RST};

endpackage

// file: core/sdf_filter_ctrl.sv
// Notes on behaviour
// R1 - Fourth order, chop and zero latency off, gives one result every 1024 x filter word clocks.
// R2 - The filter word spans 1 to 1023, and software must keep it inside that range.
// R3 - In fourth order the first settled result needs four output periods.
// R4 - A channel change resets modulator and filter, the first result waits a full settling time.
// R5 - Fourth order keeps its rate after a step, settling after four or five results.
// R6 - Mode bit 11 enables zero latency, where every conversion gets full settling.
// R7 - Fourth order zero latency has an output period of 4 x 1024 x filter word clocks.
// R8 - With zero latency only an asynchronous step can yield one unsettled result.
// R9 - The third order select bit swaps the fourth order sinc for the third order one.
// R10 - Third order, no zero latency: 1024 x filter word clocks per result, settling in three.
// R11 - Third order keeps its rate after a step, settling after three or four results.
// R12 - Third order zero latency has an output period of 3 x 1024 x filter word clocks.
// R13 - The line notch bit adds 50 Hz and 60 Hz rejection without changing the output rate.
// R14 - Chop swaps input polarity each conversion and averages successive settled conversions.
// R15 - After reset the fourth order filter is selected and chop is off.
// R16 - Each result comes with a one-cycle strobe, and the data hold until the next strobe.
// R17 - Output timing counts modulator clocks against filter word x 1024 x the period multiplier.

module sdf_fifo #(
   parameter int W     = 28,
   parameter int DEPTH = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;

   // Extra pointer bit tells full from empty; depth must be a power of two.
   assign out_valid = wr_ptr != rd_ptr;
   assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_data  = mem[rd_ptr[AW-1:0]];

   // Pointers move on accepted handshakes only.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
         if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage needs no reset, the pointers guard it.
   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule // sdf_fifo

module sdf_filter_ctrl #(
   parameter int ACC_W      = 84,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic [7:0]                 paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       mod_clk,
   input  wire logic                       mod_data,
   output logic                            mod_reset,
   output logic                            chop_swap,
   output logic [sdf_pkg::CHAN_W-1:0]      chan_sel,
   output logic                            result_strobe,
   output logic [sdf_pkg::RES_W-1:0]       result_data
);
   sdf_pkg::sdf_cfg_t       cfg;
   sdf_pkg::sdf_res_t       pend_res;
   sdf_pkg::sdf_res_t       fifo_out;
   logic [1:0]              mclk_s;
   logic [1:0]              mdat_s;
   logic                    mclk_d;
   logic                    tick;
   logic                    step;
   logic                    stall;
   logic                    pend;
   logic                    fifo_ready;
   logic                    fifo_valid;
   logic                    full_clr;
   logic                    conv_clr;
   logic                    clr;
   logic                    dec_hit;
   logic                    conv_done;
   logic                    emit;
   logic                    have_prev;
   logic                    avg_mode;
   logic                    acc;
   logic                    pop;
   logic                    wr_mode;
   logic                    wr_chan;
   logic [19:0]             dec_len;
   logic [19:0]             dec_cnt;
   logic [2:0]              ord;
   logic [2:0]              decs;
   logic [6:0]              shift;
   logic signed [ACC_W-1:0] xin;
   logic signed [ACC_W-1:0] integ [4];
   logic signed [ACC_W-1:0] dly [4];
   logic signed [ACC_W-1:0] cmb [4];
   logic signed [ACC_W-1:0] comb_in;
   logic signed [ACC_W-1:0] final_c;
   logic signed [ACC_W-1:0] scaled;
   logic signed [ACC_W-1:0] sat_hi;
   logic signed [24:0]      raw;
   logic signed [24:0]      sv;
   logic signed [24:0]      prev;
   logic signed [25:0]      sum;
   logic [23:0]             value;

   // Ceiling of log2 of the filter word, for output scaling.
   function automatic logic [3:0] clog_fw(input logic [9:0] fw);
      clog_fw = 4'h0;
      for (int i = 0; i < 10; i++) begin
         if (fw > (10'h001 << i)) clog_fw = 4'(i + 1);
      end
   endfunction

   // Modulator pins come from another clock; two stages before any use.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mclk_s <= 2'h0;
         mdat_s <= 2'h0;
         mclk_d <= 1'b0;
      end else begin
         mclk_s <= {mclk_s[0], mod_clk};
         mdat_s <= {mdat_s[0], mod_data};
         mclk_d <= mclk_s[1];
      end
   end

   // A full FIFO with a result still waiting freezes the engine, so nothing is dropped.
   assign tick      = mclk_s[1] & ~mclk_d;
   assign stall     = pend & ~fifo_ready;
   assign step      = tick & cfg.run & ~stall;
   assign ord       = cfg.third ? sdf_pkg::ORD_THIRD : sdf_pkg::ORD_FOURTH; // R9
   assign dec_len   = 20'(cfg.fw) * sdf_pkg::DEC_PER_FW; // R17
   assign dec_hit   = step && (dec_cnt == dec_len - 20'h00001); // R1 R10
   assign conv_done = dec_hit && (decs >= ord - 3'h1) && !full_clr; // R3 R10
   assign conv_clr  = conv_done && (cfg.zero_lat || cfg.chop); // R6 R7 R12 R14
   assign clr       = full_clr || conv_clr;
   assign avg_mode  = cfg.chop || cfg.notch;
   assign emit      = conv_done && (!avg_mode || have_prev);
   assign xin       = {{(ACC_W-1){~mdat_s[1]}}, 1'b1};

   // Integrators run at the modulator rate; a clear restarts the settling.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) integ[i] <= '0;
      end else if (clr) begin
         for (int i = 0; i < 4; i++) integ[i] <= '0; // R4 R8
      end else if (step) begin
         integ[0] <= integ[0] + xin;
         for (int i = 1; i < 4; i++) integ[i] <= integ[i] + integ[i-1];
      end
   end

   // Comb chain; the third order path taps one stage early on both ends.
   assign comb_in = cfg.third ? integ[2] : integ[3]; // R9
   always_comb begin
      cmb[0] = comb_in - dly[0];
      for (int i = 1; i < 4; i++) cmb[i] = cmb[i-1] - dly[i];
      final_c = cfg.third ? cmb[2] : cmb[3];
   end

   // Comb delays update once per decimation step.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) dly[i] <= '0;
      end else if (clr) begin
         for (int i = 0; i < 4; i++) dly[i] <= '0;
      end else if (dec_hit) begin
         dly[0] <= comb_in;
         for (int i = 1; i < 4; i++) dly[i] <= cmb[i-1];
      end
   end

   // Decimation counter and count of decimations since the last clear.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dec_cnt <= '0;
         decs    <= '0;
      end else if (clr) begin
         dec_cnt <= '0; // R4
         decs    <= '0;
      end else if (dec_hit) begin
         dec_cnt <= '0;
         if (decs < sdf_pkg::ORD_FOURTH) decs <= decs + 3'h1; // R3 R5 R11
      end else if (step) begin
         dec_cnt <= dec_cnt + 20'h00001; // R17
      end
   end

   // Gain is dec_len to the power of the order; shift it back to 24 bits.
   assign shift  = 7'(ord) * (7'(clog_fw(cfg.fw)) + sdf_pkg::DEC_LOG2) - sdf_pkg::RES_TOP;
   assign sat_hi = ACC_W'(sdf_pkg::RES_MAX);

   // Symmetric clamp so that negation and averaging never overflow.
   always_comb begin
      scaled = final_c >>> shift;
      if (scaled > sat_hi) begin
         raw = {1'b0, sdf_pkg::RES_MAX};
      end else if (scaled < -sat_hi) begin
         raw = -{1'b0, sdf_pkg::RES_MAX};
      end else begin
         raw = scaled[24:0];
      end
      sv    = chop_swap ? -raw : raw; // R14
      sum   = 26'(sv) + 26'(prev);
      value = avg_mode ? sum[24:1] : sv[23:0]; // R13 R14
   end

   // History for averaging and the chop polarity; a channel or mode change wipes both.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev      <= '0;
         have_prev <= 1'b0;
         chop_swap <= 1'b0;
      end else if (full_clr) begin
         have_prev <= 1'b0;
         chop_swap <= 1'b0;
      end else if (conv_done) begin
         prev      <= sv;
         have_prev <= 1'b1;
         if (cfg.chop) chop_swap <= ~chop_swap; // R14
      end
   end

   // The modulator restarts with every filter clear.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) mod_reset <= 1'b0;
      else mod_reset <= clr; // R4
   end

   // Result strobe and data, loaded together.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         result_strobe <= 1'b0;
         result_data   <= '0;
      end else begin
         result_strobe <= emit; // R16
         if (emit) result_data <= value; // R16
      end
   end

   // One result waits here until the FIFO takes it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend     <= 1'b0;
         pend_res <= '0;
      end else if (emit) begin
         pend     <= 1'b1;
         pend_res <= '{chan: chan_sel, data: value};
      end else if (fifo_ready) begin
         pend <= 1'b0;
      end
   end

   sdf_fifo #(
      .W     ($bits(sdf_pkg::sdf_res_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (pend),
      .in_ready  (fifo_ready),
      .in_data   (pend_res),
      .out_valid (fifo_valid),
      .out_ready (pop),
      .out_data  (fifo_out)
   );

   // Zero wait state slave; unmapped offsets answer with an error.
   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = acc && (paddr != sdf_pkg::OFS_MODE) && (paddr != sdf_pkg::OFS_CHAN)
                    && (paddr != sdf_pkg::OFS_STAT) && (paddr != sdf_pkg::OFS_DATA);
   assign pop     = acc && !pwrite && (paddr == sdf_pkg::OFS_DATA);
   assign wr_mode = acc && pwrite && (paddr == sdf_pkg::OFS_MODE);
   assign wr_chan = acc && pwrite && (paddr == sdf_pkg::OFS_CHAN);

   // Mode and channel registers; a zero filter word is refused and the old one kept.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg      <= sdf_pkg::CFG_RST; // R15
         chan_sel <= '0;
         full_clr <= 1'b0;
      end else begin
         full_clr <= wr_mode || wr_chan; // R4
         if (wr_chan) chan_sel <= pwdata[sdf_pkg::CHAN_W-1:0];
         if (wr_mode) begin
            cfg.run      <= pwdata[sdf_pkg::MB_RUN];
            cfg.chop     <= pwdata[sdf_pkg::MB_CHOP];
            cfg.notch    <= pwdata[sdf_pkg::MB_NOTCH];
            cfg.third    <= pwdata[sdf_pkg::MB_THIRD];
            cfg.zero_lat <= pwdata[sdf_pkg::MB_ZL]; // R6
            if (pwdata[sdf_pkg::MB_FW +: 10] != sdf_pkg::FW_ZERO) begin
               cfg.fw <= pwdata[sdf_pkg::MB_FW +: 10]; // R2
            end
         end
      end
   end

   // Read mux; the data word carries a valid flag so an empty read is harmless.
   always_comb begin
      prdata = '0;
      case (paddr)
         sdf_pkg::OFS_MODE: begin
            prdata[sdf_pkg::MB_RUN]      = cfg.run;
            prdata[sdf_pkg::MB_CHOP]     = cfg.chop;
            prdata[sdf_pkg::MB_NOTCH]    = cfg.notch;
            prdata[sdf_pkg::MB_THIRD]    = cfg.third;
            prdata[sdf_pkg::MB_ZL]       = cfg.zero_lat;
            prdata[sdf_pkg::MB_FW +: 10] = cfg.fw;
         end
         sdf_pkg::OFS_CHAN: begin
            prdata[sdf_pkg::CHAN_W-1:0] = chan_sel;
         end
         sdf_pkg::OFS_STAT: begin
            prdata[sdf_pkg::SB_AVAIL]     = fifo_valid;
            prdata[sdf_pkg::SB_FULL]      = !fifo_ready;
            prdata[sdf_pkg::SB_SWAP]      = chop_swap;
            prdata[sdf_pkg::SB_PEND]      = pend;
            prdata[sdf_pkg::SB_DECS +: 3] = decs;
         end
         sdf_pkg::OFS_DATA: begin
            if (fifo_valid) begin
               prdata[sdf_pkg::DB_VALID]                = 1'b1;
               prdata[sdf_pkg::DB_CHAN +: sdf_pkg::CHAN_W] = fifo_out.chan;
               prdata[sdf_pkg::RES_W-1:0]               = fifo_out.data;
            end
         end
         default: prdata = '0;
      endcase
   end

   // Checking aids: steps between results and decimations since a full clear.
   logic [22:0] h_gap;
   logic        h_seen;
   logic [2:0]  h_decs;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         h_gap  <= '0;
         h_seen <= 1'b0;
         h_decs <= '0;
      end else begin
         if (full_clr) begin
            h_gap  <= '0;
            h_seen <= 1'b0;
         end else if (emit) begin
            h_gap  <= '0;
            h_seen <= 1'b1;
         end else if (step) begin
            h_gap <= h_gap + 23'h000001;
         end
         if (full_clr) h_decs <= '0;
         else if (dec_hit && h_decs != 3'h7) h_decs <= h_decs + 3'h1;
      end
   end

   property p_strobe_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
      result_strobe |=> !result_strobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("Strobe too long."); // R16

   property p_data_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      !result_strobe |-> $stable(result_data);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("Data moved off strobe."); // R16

   property p_fw_range;
      @(posedge clk_sys) disable iff (!rst_n)
      cfg.fw != sdf_pkg::FW_ZERO;
   endproperty
   a_fw_range: assert property (p_fw_range) else $error("Filter word is zero."); // R2

   property p_reset_default;
      @(posedge clk_sys)
      $rose(rst_n) |-> (!cfg.third && !cfg.chop && !cfg.zero_lat);
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("Bad reset mode."); // R15

   property p_rate;
      @(posedge clk_sys) disable iff (!rst_n)
      (emit && h_seen && !cfg.zero_lat && !cfg.chop) |-> (h_gap + 23'h000001 == 23'(dec_len));
   endproperty
   a_rate: assert property (p_rate) else $error("Wrong output period."); // R1 R10 R13 R17

   property p_zl_rate;
      @(posedge clk_sys) disable iff (!rst_n)
      (emit && h_seen && cfg.zero_lat && !avg_mode)
         |-> (h_gap + 23'h000001 == 23'(dec_len) * 23'(ord));
   endproperty
   a_zl_rate: assert property (p_zl_rate) else $error("Wrong settled period."); // R7 R12

   property p_settle;
      @(posedge clk_sys) disable iff (!rst_n)
      (emit && !cfg.zero_lat && !cfg.chop) |=> (h_decs >= $past(ord));
   endproperty
   a_settle: assert property (p_settle) else $error("Result before settling."); // R3 R5 R11

   property p_chan_clr;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_chan |=> full_clr ##1 (mod_reset && decs == 3'h0 && !have_prev);
   endproperty
   a_chan_clr: assert property (p_chan_clr) else $error("Channel change not reset."); // R4

   property p_zl_clear;
      @(posedge clk_sys) disable iff (!rst_n)
      (conv_done && cfg.zero_lat) |=> (mod_reset && decs == 3'h0 && dec_cnt == 20'h0);
   endproperty
   a_zl_clear: assert property (p_zl_clear) else $error("No restart after conversion."); // R6 R8

   property p_chop;
      @(posedge clk_sys) disable iff (!rst_n)
      (conv_done && cfg.chop) |=> (chop_swap != $past(chop_swap));
   endproperty
   a_chop: assert property (p_chop) else $error("Chop polarity did not swap."); // R14
endmodule // sdf_filter_ctrl

// file: verification/sdf_mod_src.sv
module sdf_mod_src (
   input  wire logic clk_sys,
   input  wire logic rand_en,
   output logic      mod_clk,
   output logic      mod_data,
   output int        ticks
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase = 2'h0;
   logic       bit_q = 1'b1;
   int         cnt   = 0;

   // The master clock runs free at four system clocks a period, so no edge is lost.
   always_ff @(posedge clk_sys) begin
      phase <= phase + 2'h1;
   end

   // Bits change while the clock is low, well away from the rise that samples them.
   always_ff @(posedge clk_sys) begin
      if (phase == 2'h0) begin
         bit_q <= rand_en ? 1'($urandom) : 1'b1;
      end
      if (phase == 2'h1) begin
         cnt <= cnt + 1;
      end
   end

   // A constant one stream is full scale, which gives the bench a result it can predict.
   assign mod_clk  = phase[1];
   assign mod_data = bit_q;
   assign ticks    = cnt;
endmodule // sdf_mod_src

// file: verification/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int L = 1024;
   logic                          clk_sys = 1'b0;
   logic                          rst_n   = 1'b0;
   logic [7:0]                    paddr   = 8'h00;
   logic                          psel    = 1'b0;
   logic                          penable = 1'b0;
   logic                          pwrite  = 1'b0;
   logic [31:0]                   pwdata  = 32'h0;
   logic [31:0]                   prdata;
   logic                          pready;
   logic                          pslverr;
   logic                          mod_clk;
   logic                          mod_data;
   logic                          mod_reset;
   logic                          chop_swap;
   logic [sdf_pkg::CHAN_W-1:0]    chan_sel;
   logic                          result_strobe;
   logic [sdf_pkg::RES_W-1:0]     result_data;
   logic                          rand_en = 1'b0;
   int                            ticks;
   int                            fail_count = 0;
   int                            comparisons = 0;
   int                            t0;
   int                            ts;
   int                            n;
   logic [31:0]                   rd;
   logic                          err;
   logic [3:0]                    ch;
   logic [9:0]                    fw;
   logic [31:0]                   mw;

   sdf_filter_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mod_clk(mod_clk), .mod_data(mod_data), .mod_reset(mod_reset),
      .chop_swap(chop_swap), .chan_sel(chan_sel), .result_strobe(result_strobe),
      .result_data(result_data));
   sdf_mod_src src (.clk_sys(clk_sys), .rand_en(rand_en), .mod_clk(mod_clk),
      .mod_data(mod_data), .ticks(ticks));

   // Free running system clock, 8 ns period.
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   // Single place where the run ends.
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task chk_v(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task chk_n(input int got, input int exp, input int tol);
      comparisons++;
      if (got < exp - tol || got > exp + tol) begin
         fail_count++;
         $display("MISMATCH %0t ticks %0d expected %0d", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] mode_w(input logic run, input logic third, input logic zl,
                                          input logic [9:0] f);
      logic [31:0] v;
      v = 32'h0;
      v[9:0] = f;
      v[sdf_pkg::MB_RUN] = run;
      v[sdf_pkg::MB_THIRD] = third;
      v[sdf_pkg::MB_ZL] = zl;
      return v;
   endfunction

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         results;
      end
   endtask

   // Waits for a result strobe; the held result must not move in between.
   task wait_strobe(input int tmax);
      int k;
      logic [23:0] held;
      held = result_data;
      for (k = 0; k < tmax * 4 + 64; k++) begin
         @(posedge clk_sys);
         if (result_strobe === 1'b1) break;
         chk_v({8'h0, result_data}, {8'h0, held});
      end
      ts = ticks;
      if (result_strobe !== 1'b1) begin
         fail_count++;
         results;
      end
   endtask

   // Main sequence: registers, channel change, full-rate fill, drain, third order zero latency.
   initial begin
      rd = $urandom(32'he658);
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, sdf_pkg::OFS_MODE, 32'h0);
      chk_v(rd, mode_w(1'b0, 1'b0, 1'b0, 10'h060));
      apb(1'b0, 8'h10, 32'h0);
      chk_v({rd[31:1], err}, 32'h1);
      fw = 10'(1 + $urandom_range(1022));
      apb(1'b1, sdf_pkg::OFS_MODE, mode_w(1'b0, 1'b0, 1'b0, fw));
      apb(1'b0, sdf_pkg::OFS_MODE, 32'h0);
      chk_v(rd, mode_w(1'b0, 1'b0, 1'b0, fw));
      apb(1'b1, sdf_pkg::OFS_MODE, mode_w(1'b0, 1'b1, 1'b1, 10'h000));
      apb(1'b0, sdf_pkg::OFS_MODE, 32'h0);
      chk_v(rd, mode_w(1'b0, 1'b1, 1'b1, fw));
      ch = 4'($urandom);
      apb(1'b1, sdf_pkg::OFS_CHAN, {28'h0, ch});
      n = 0;
      while (mod_reset !== 1'b1 && n < 8) begin
         @(posedge clk_sys);
         n++;
      end
      chk_n(n, 2, 0);
      chk_v({28'h0, chan_sel}, {28'h0, ch});
      // Fourth order at the smallest filter word, eight results fill the buffer.
      apb(1'b1, sdf_pkg::OFS_MODE, mode_w(1'b1, 1'b0, 1'b0, 10'h001));
      t0 = ticks;
      wait_strobe(4 * L + 8);
      chk_n(ts - t0, 4 * L, 2);
      chk_v({8'h0, result_data}, {8'h0, sdf_pkg::RES_MAX});
      @(posedge clk_sys);
      chk_v({31'h0, result_strobe}, 32'h0);
      repeat (7) begin
         t0 = ts;
         wait_strobe(L + 8);
         chk_n(ts - t0, L, 0);
      end
      repeat (4) @(posedge clk_sys);
      apb(1'b0, sdf_pkg::OFS_STAT, 32'h0);
      chk_v({30'h0, rd[1:0]}, 32'h3);
      repeat (8) begin
         apb(1'b0, sdf_pkg::OFS_DATA, 32'h0);
         chk_v(rd, {1'b1, 3'h0, ch, sdf_pkg::RES_MAX});
      end
      apb(1'b0, sdf_pkg::OFS_DATA, 32'h0);
      chk_v(rd, 32'h0);
      // Third order with zero latency on a random bit stream.
      rand_en <= 1'b1;
      apb(1'b1, sdf_pkg::OFS_MODE, mode_w(1'b1, 1'b1, 1'b1, 10'h001));
      t0 = ticks;
      wait_strobe(3 * L + 8);
      chk_n(ts - t0, 3 * L, 2);
      t0 = ts;
      wait_strobe(3 * L + 8);
      chk_n(ts - t0, 3 * L, 0);
      // Chop with the line notch: the polarity swaps after the first settled conversion, and no result
      // leaves before that swap.
      mw = mode_w(1'b1, 1'b1, 1'b0, 10'h001) | (32'h1 << sdf_pkg::MB_CHOP)
           | (32'h1 << sdf_pkg::MB_NOTCH);
      apb(1'b1, sdf_pkg::OFS_MODE, mw);
      t0 = ticks;
      apb(1'b0, sdf_pkg::OFS_MODE, 32'h0);
      chk_v(rd, mw);
      n = 0;
      while (chop_swap !== 1'b1 && n < 3 * L * 4 + 64) begin
         @(posedge clk_sys);
         n++;
         chk_v({31'h0, result_strobe}, 32'h0);
      end
      chk_n(ticks - t0, 3 * L, 2);
      apb(1'b0, sdf_pkg::OFS_STAT, 32'h0);
      chk_v({31'h0, rd[sdf_pkg::SB_SWAP]}, 32'h1);
      results;
   end
endmodule // tb
